// >>> verilog/ffsel_defines.svh
// Constants for the fixed frequency setpoint selector: codes, widths, reset values.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FFSEL_DEFINES_SVH
`define FFSEL_DEFINES_SVH

`define FFSEL_FREQ_W         16
`define FFSEL_SLOT_CNT       8
`define FFSEL_FUNC_W         8
`define FFSEL_FUNC_DIRECT_RUN 8'h10
`define FFSEL_FUNC_BINARY_RUN 8'h11
`define FFSEL_METHOD_W       2
`define FFSEL_METHOD_DIRECT  2'h1
`define FFSEL_METHOD_DRUN    2'h2
`define FFSEL_METHOD_BRUN    2'h3
`define FFSEL_SRC_W          4
`define FFSEL_SRC_FIXED      4'h3
`define FFSEL_ROUTE_W        4
`define FFSEL_ROUTE_FIXED    4'h3
`define FFSEL_ROUTE_NONE     4'h0
`define FFSEL_ADDR_W         4
`define FFSEL_ADDR_METHOD    4'h0
`define FFSEL_ADDR_FUNC1     4'h1
`define FFSEL_ADDR_FUNC2     4'h2
`define FFSEL_ADDR_FUNC3     4'h3
`define FFSEL_ADDR_SRC       4'h4
`define FFSEL_ADDR_ALT       4'h5
`define FFSEL_ADDR_MAIN      4'h6
`define FFSEL_ADDR_SUPP      4'h7
`define FFSEL_ADDR_STATUS    4'h8
`define FFSEL_ADDR_SLOT1     4'h9
`define FFSEL_ADDR_SLOT7     4'hF
`define FFSEL_RST_METHOD     2'h1

`endif

// >>> verilog/ffsel_pkg.sv
// Types shared by the fixed frequency selector.
// Assumes ffsel_defines.svh is on the include path.
`include "ffsel_defines.svh"
package ffsel_pkg;
    typedef enum logic [1:0] {
        FFSEL_MODE_NONE   = 2'b00,
        FFSEL_MODE_DIRECT = 2'b01,
        FFSEL_MODE_DRUN   = 2'b10,
        FFSEL_MODE_BRUN   = 2'b11
    } ffsel_mode_t;
endpackage : ffsel_pkg

// >>> verilog/ffsel_top.sv
// Fixed frequency setpoint selector: slot table, mode decode, setpoint and run outputs.
// Assumes selects arrive synchronous to mclk_in and software uses the plain register port.
// Assumes the package is compiled before this file and the constants header is on
// the include path. The block has no interrupt and no buffering of its own.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "ffsel_defines.svh"
module ffsel_top (
    input  wire logic                      mclk_in,          // 10 MHz clock.
    input  wire logic                      reset_n_in,       // Async reset, active low.
    input  wire logic                      select_input_one_in,   // Select signal one.
    input  wire logic                      select_input_two_in,   // Select signal two.
    input  wire logic                      select_input_three_in, // Select signal three.
    input  wire logic [`FFSEL_ADDR_W-1:0]  addr_in,          // Register address.
    input  wire logic [15:0]               wdata_in,         // Write data.
    input  wire logic                      wr_in,            // Write strobe.
    input  wire logic                      rd_in,            // Read strobe.
    output logic      [15:0]               rdata_out,        // Read data, cycle after rd_in.
    output logic      [`FFSEL_FREQ_W-1:0]  effective_preset_output_out, // Effective setpoint.
    output logic                           run_cmd_out,      // Derived run command.
    output logic                           fixed_source_out  // Fixed frequencies feed main route.
);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [`FFSEL_FREQ_W-1:0]   slot_reg [1:7];
    logic [`FFSEL_METHOD_W-1:0] selection_method_code_reg;
    logic [`FFSEL_FUNC_W-1:0]   func_reg [1:3];
    logic [`FFSEL_SRC_W-1:0]    setpoint_source_selector_reg;
    logic [`FFSEL_SRC_W-1:0]    alternate_source_selector_reg;
    logic [`FFSEL_ROUTE_W-1:0]  main_setpoint_route_reg;
    logic [`FFSEL_ROUTE_W-1:0]  supplementary_setpoint_route_reg;
    logic [`FFSEL_FREQ_W-1:0]   setpoint_next;
    logic                       run_next;
    ffsel_pkg::ffsel_mode_t     mode;
    logic [2:0]                 sel;

    // Select vector, input one in the least significant bit. The same vector
    // serves as a direct-mode enable mask and as the binary-mode index, so the
    // bit order matters to both decoders.
    assign sel = {select_input_three_in, select_input_two_in, select_input_one_in};

    // ----------------------------------------------------------------
    // Slot table
    // ----------------------------------------------------------------
    // Programmable slots one to seven; slot zero has no storage and is always 0 Hz.
    // The slot addresses are the top of the map, so anything at or above the
    // first slot address is a slot write. Keeping slot zero out of storage saves
    // a register and makes a stray write unable to give a nonzero idle setpoint.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 1; i < `FFSEL_SLOT_CNT; i++) begin
                slot_reg[i] <= '0;
            end
        end else if (wr_in && addr_in >= `FFSEL_ADDR_SLOT1) begin
            slot_reg[3'(addr_in - `FFSEL_ADDR_SLOT1) + 3'h1] <= wdata_in;
        end
    end

    // ----------------------------------------------------------------
    // Mode configuration
    // ----------------------------------------------------------------
    // Method code and per-input function codes. The method code resets to
    // direct selection, so a fresh device sums the selected slots at once;
    // the function codes reset to zero, which overrides nothing.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            selection_method_code_reg <= `FFSEL_RST_METHOD;
            func_reg[1] <= '0;
            func_reg[2] <= '0;
            func_reg[3] <= '0;
        end else if (wr_in) begin
            if (addr_in == `FFSEL_ADDR_METHOD) begin
                selection_method_code_reg <= wdata_in[`FFSEL_METHOD_W-1:0];
            end else if (addr_in == `FFSEL_ADDR_FUNC1) begin
                func_reg[1] <= wdata_in[`FFSEL_FUNC_W-1:0];
            end else if (addr_in == `FFSEL_ADDR_FUNC2) begin
                func_reg[2] <= wdata_in[`FFSEL_FUNC_W-1:0];
            end else if (addr_in == `FFSEL_ADDR_FUNC3) begin
                func_reg[3] <= wdata_in[`FFSEL_FUNC_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Setpoint source and routing
    // ----------------------------------------------------------------
    // Source selectors. Writing the main selector rewrites both routes; the
    // alternate selector deliberately leaves the routing alone.
    // The supplementary route is cleared on every main selector write, so a
    // route set up by hand does not survive a later change of source; software
    // that wants both must write the routes after the selector.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            setpoint_source_selector_reg     <= '0;
            alternate_source_selector_reg    <= '0;
            main_setpoint_route_reg          <= `FFSEL_ROUTE_NONE;
            supplementary_setpoint_route_reg <= `FFSEL_ROUTE_NONE;
        end else if (wr_in) begin
            if (addr_in == `FFSEL_ADDR_SRC) begin
                setpoint_source_selector_reg     <= wdata_in[`FFSEL_SRC_W-1:0];
                main_setpoint_route_reg          <= (wdata_in[`FFSEL_SRC_W-1:0] == `FFSEL_SRC_FIXED) ?
                                                    `FFSEL_ROUTE_FIXED : wdata_in[`FFSEL_ROUTE_W-1:0];
                supplementary_setpoint_route_reg <= `FFSEL_ROUTE_NONE;
            end else if (addr_in == `FFSEL_ADDR_ALT) begin
                alternate_source_selector_reg    <= wdata_in[`FFSEL_SRC_W-1:0];
            end else if (addr_in == `FFSEL_ADDR_MAIN) begin
                main_setpoint_route_reg          <= wdata_in[`FFSEL_ROUTE_W-1:0];
            end else if (addr_in == `FFSEL_ADDR_SUPP) begin
                supplementary_setpoint_route_reg <= wdata_in[`FFSEL_ROUTE_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode decode: input-one function code wins over the method code.
    // ----------------------------------------------------------------
    // A function code on input one is the quick way to pick a mode, so it takes
    // precedence; method code zero decodes to no mode, which holds the setpoint
    // at zero and the run command low rather than guessing.
    always_comb begin
        if (func_reg[1] == `FFSEL_FUNC_BINARY_RUN) begin
            mode = ffsel_pkg::FFSEL_MODE_BRUN;
        end else if (func_reg[1] == `FFSEL_FUNC_DIRECT_RUN) begin
            mode = ffsel_pkg::FFSEL_MODE_DRUN;
        end else begin
            mode = ffsel_pkg::ffsel_mode_t'(selection_method_code_reg);
        end
    end

    // ----------------------------------------------------------------
    // Setpoint and run
    // ----------------------------------------------------------------
    // Setpoint and run for the current mode. Sums wrap at the field width;
    // software must keep slot sums in range.
    // Direct modes add the enabled slots one to three; binary mode reads one
    // slot by index. In both, no select asserted means no run, so releasing
    // every select always stops the drive whatever the mode.
    always_comb begin
        setpoint_next = '0;
        run_next      = 1'b0;
        case (mode)
            ffsel_pkg::FFSEL_MODE_DIRECT,
            ffsel_pkg::FFSEL_MODE_DRUN: begin
                // Slot i+1 answers select bit i; several selects add up.
                for (int i = 0; i < 3; i++) begin
                    if (sel[i]) begin
                        setpoint_next = setpoint_next + slot_reg[i+1];
                    end
                end
                run_next = (mode == ffsel_pkg::FFSEL_MODE_DRUN) && (sel != 3'h0);
            end
            ffsel_pkg::FFSEL_MODE_BRUN: begin
                // Index zero has no slot register, so it is decoded to 0 Hz here.
                setpoint_next = (sel == 3'h0) ? '0 : slot_reg[sel];
                // Run needs all three inputs set to the binary code, not only input one.
                run_next      = (func_reg[1] == `FFSEL_FUNC_BINARY_RUN) &&
                                (func_reg[2] == `FFSEL_FUNC_BINARY_RUN) &&
                                (func_reg[3] == `FFSEL_FUNC_BINARY_RUN) && (sel != 3'h0);
            end
            default: begin
                setpoint_next = '0;
                run_next      = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Registered outputs, one cycle behind any change. Registering costs one
    // cycle of latency but keeps the adder chain off the output pins, so the
    // setpoint never shows a partial sum.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            effective_preset_output_out <= '0;
            run_cmd_out                 <= 1'b0;
            fixed_source_out            <= 1'b0;
        end else begin
            effective_preset_output_out <= setpoint_next;
            run_cmd_out                 <= run_next;
            fixed_source_out            <= (main_setpoint_route_reg == `FFSEL_ROUTE_FIXED);
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Read data stand for one cycle after the strobe and are zero otherwise,
    // so a bus that ORs several slaves' read data sees only this one.
    // Narrow fields sit in the low bits with the upper bits read as zero; the
    // status word shows the run command in bit 15 and the selects in bits 11:9.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            if (addr_in == `FFSEL_ADDR_METHOD) begin
                rdata_out <= {14'h0000, selection_method_code_reg};
            end else if (addr_in == `FFSEL_ADDR_FUNC1) begin
                rdata_out <= {8'h00, func_reg[1]};
            end else if (addr_in == `FFSEL_ADDR_FUNC2) begin
                rdata_out <= {8'h00, func_reg[2]};
            end else if (addr_in == `FFSEL_ADDR_FUNC3) begin
                rdata_out <= {8'h00, func_reg[3]};
            end else if (addr_in == `FFSEL_ADDR_SRC) begin
                rdata_out <= {12'h000, setpoint_source_selector_reg};
            end else if (addr_in == `FFSEL_ADDR_ALT) begin
                rdata_out <= {12'h000, alternate_source_selector_reg};
            end else if (addr_in == `FFSEL_ADDR_MAIN) begin
                rdata_out <= {12'h000, main_setpoint_route_reg};
            end else if (addr_in == `FFSEL_ADDR_SUPP) begin
                rdata_out <= {12'h000, supplementary_setpoint_route_reg};
            end else if (addr_in == `FFSEL_ADDR_STATUS) begin
                rdata_out <= {run_cmd_out, 3'h0, sel, 9'h000};
            end else begin
                rdata_out <= slot_reg[3'(addr_in - `FFSEL_ADDR_SLOT1) + 3'h1];
            end
        end else begin
            rdata_out <= '0;
        end
    end

endmodule : ffsel_top

// >>> bench/ffsel_chk.sv
// Checker for the fixed frequency selector ports.
// Assumes it is bound to ffsel_top.
`timescale 1ns/100ps
`include "ffsel_defines.svh"
module ffsel_chk (
    input wire logic                     mclk_in,                     // Clock.
    input wire logic                     reset_n_in,                  // Reset.
    input wire logic                     select_input_one_in,         // Select one.
    input wire logic                     select_input_two_in,         // Select two.
    input wire logic                     select_input_three_in,       // Select three.
    input wire logic [`FFSEL_ADDR_W-1:0] addr_in,                     // Address.
    input wire logic [15:0]              wdata_in,                    // Write data.
    input wire logic                     wr_in,                       // Write strobe.
    input wire logic [`FFSEL_FREQ_W-1:0] effective_preset_output_out, // Setpoint.
    input wire logic                     run_cmd_out,                 // Run.
    input wire logic                     fixed_source_out             // Fixed source.
);
    // -------------------------------------------------------------------
    // Properties.
    // -------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic no_sel = !select_input_one_in && !select_input_two_in && !select_input_three_in;
    // Quiet needs two settled edges after reset, or the held outputs look like a step.
    sequence s_quiet;
        !wr_in && !$past(wr_in) && $past(reset_n_in, 2);
    endsequence
    sequence s_src_wr;
        wr_in && addr_in == `FFSEL_ADDR_SRC;
    endsequence
    a_zero_slot: assert property (no_sel |=> effective_preset_output_out == '0)
        else $error("setpoint not zero without selects");
    a_zero_run: assert property (no_sel |=> !run_cmd_out)
        else $error("run without selects");
    a_run_cause: assert property (run_cmd_out |-> !$past(no_sel))
        else $error("run with no select one edge earlier");
    a_src_fixed: assert property (s_src_wr ##0 wdata_in[3:0] == 4'h3 |-> ##2 fixed_source_out)
        else $error("fixed source not routed");
    a_src_other: assert property (s_src_wr ##0 wdata_in[3:0] != 4'h3 |-> ##2 !fixed_source_out)
        else $error("fixed source routed for other code");
    a_alt_keeps: assert property (wr_in && addr_in == `FFSEL_ADDR_ALT |-> ##2 $stable(fixed_source_out))
        else $error("alternate selector changed routing");
    a_hold_set: assert property (s_quiet ##0 $stable(select_input_one_in) ##0 $stable(select_input_two_in)
        ##0 $stable(select_input_three_in) |=> $stable(effective_preset_output_out))
        else $error("setpoint moved without cause");
    a_hold_run: assert property (s_quiet ##0 $stable(no_sel) |=> $stable(run_cmd_out))
        else $error("run moved without cause");
endmodule : ffsel_chk
bind ffsel_top ffsel_chk u_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .select_input_one_in(select_input_one_in), .select_input_two_in(select_input_two_in),
    .select_input_three_in(select_input_three_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .effective_preset_output_out(effective_preset_output_out), .run_cmd_out(run_cmd_out),
    .fixed_source_out(fixed_source_out));

// >>> bench/ffsel_terminals.sv
// Digital input terminal model driving the three select lines.
// Assumes the bench sets the pattern just after a clock edge.
`timescale 1ns/100ps
module ffsel_terminals (
    input  wire logic       mclk_in,       // Clock.
    input  wire logic [2:0] pattern_in,    // Pattern, bit 0 is input one.
    output logic            sel_one_out,   // Select one.
    output logic            sel_two_out,   // Select two.
    output logic            sel_three_out  // Select three.
);
    logic [2:0] level_q = 3'h0; // Terminal levels, low at power-up.

    // Terminals start low and move one edge after the pattern, like a sampled input stage.
    always @(posedge mclk_in) begin
        level_q <= pattern_in;
    end
    assign {sel_three_out, sel_two_out, sel_one_out} = level_q;
endmodule : ffsel_terminals

// >>> bench/ffsel_tb_top.sv
// Testbench for the fixed frequency selector: register tasks and select sweeps.
// Assumes the design, terminal model and bound checker are compiled first.
`timescale 1ns/100ps
`include "ffsel_defines.svh"
module ffsel_tb_top;
    logic mclk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, rdata, setpoint;
    logic [2:0] pattern = 3'h0;
    logic s1, s2, s3, run, fixed;
    logic [15:0] slot_val [8];
    int mismatches = 0, checks = 0, cycles = 0;
    always #50 mclk_in = ~mclk_in;
    ffsel_terminals u_term (.mclk_in(mclk_in), .pattern_in(pattern), .sel_one_out(s1), .sel_two_out(s2),
        .sel_three_out(s3));
    ffsel_top DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .select_input_one_in(s1),
        .select_input_two_in(s2), .select_input_three_in(s3), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .effective_preset_output_out(setpoint),
        .run_cmd_out(run), .fixed_source_out(fixed));
    // -------------------------------------------------------------------
    // Tasks.
    // -------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so look just after that edge.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_in);
        {rd_in, addr_in} <= {1'b1, a};
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", rdata, exp);
    endtask : rd
    // Kind: bit 1 picks binary indexing, bit 0 expects the run command; kind 4 expects no setpoint.
    task automatic sweep(input int kind);
        logic [15:0] exp;
        for (int p = 0; p < 8; p++) begin
            @(posedge mclk_in);
            pattern <= 3'(p);
            repeat (3) @(posedge mclk_in);
            #1;
            if (kind == 4) begin
                exp = 16'h0000;
            end else if (kind < 2) begin
                exp = (p[0] ? slot_val[1] : 16'h0000) + (p[1] ? slot_val[2] : 16'h0000);
                exp = exp + (p[2] ? slot_val[3] : 16'h0000);
            end else begin
                exp = slot_val[p];
            end
            chk("setpoint", setpoint, exp);
            chk("run", {15'h0, run}, {15'h0, kind[0] && p != 0});
        end
        $display("test sweep %0d done", kind);
    endtask : sweep
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // The ceiling is far above the few hundred cycles the sequence needs.
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // -------------------------------------------------------------------
    // Main sequence.
    // -------------------------------------------------------------------
    initial begin
        slot_val[0] = 16'h0000;
        repeat (16) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        rd(`FFSEL_ADDR_METHOD, 16'h0001);
        rd(`FFSEL_ADDR_SLOT1, 16'h0000);
        for (int i = 1; i < 8; i++) begin
            slot_val[i] = 16'(i) * 16'h0111;
            wr(4'(`FFSEL_ADDR_SLOT1 + i - 1), slot_val[i]);
        end
        rd(`FFSEL_ADDR_SLOT7, 16'h0777);
        $display("test slots done");
        sweep(0);
        wr(`FFSEL_ADDR_METHOD, 16'h0002);
        sweep(1);
        wr(`FFSEL_ADDR_METHOD, 16'h0000);
        sweep(4);
        wr(`FFSEL_ADDR_FUNC1, 16'h0010);
        sweep(1);
        wr(`FFSEL_ADDR_FUNC1, 16'h0000);
        wr(`FFSEL_ADDR_METHOD, 16'h0003);
        sweep(2);
        wr(`FFSEL_ADDR_METHOD, 16'h0001);
        wr(`FFSEL_ADDR_FUNC1, 16'h0011);
        sweep(2);
        wr(`FFSEL_ADDR_FUNC2, 16'h0011);
        wr(`FFSEL_ADDR_FUNC3, 16'h0011);
        sweep(3);
        rd(`FFSEL_ADDR_STATUS, 16'h8E00);
        wr(`FFSEL_ADDR_SUPP, 16'h0005);
        wr(`FFSEL_ADDR_SRC, 16'h0003);
        @(posedge mclk_in) #1 chk("fixed", {15'h0, fixed}, 16'h0001);
        rd(`FFSEL_ADDR_MAIN, 16'h0003);
        rd(`FFSEL_ADDR_SUPP, 16'h0000);
        rd(`FFSEL_ADDR_SRC, 16'h0003);
        wr(`FFSEL_ADDR_SUPP, 16'h0002);
        wr(`FFSEL_ADDR_ALT, 16'h0001);
        @(posedge mclk_in) #1 chk("fixed", {15'h0, fixed}, 16'h0001);
        rd(`FFSEL_ADDR_SUPP, 16'h0002);
        rd(`FFSEL_ADDR_MAIN, 16'h0003);
        rd(`FFSEL_ADDR_ALT, 16'h0001);
        wr(`FFSEL_ADDR_SRC, 16'h0001);
        @(posedge mclk_in) #1 chk("fixed", {15'h0, fixed}, 16'h0000);
        $display("test routing done");
        summarize();
    end
endmodule : ffsel_tb_top
